// ===== verilog/ecl_pkg.sv
// Purpose: shared constants and types of the configuration loader
// Assumes: 10 MHz system clock
// Notes: times in microseconds, cycle counts derived from CLK_MHZ
package ecl_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 10;
  localparam int T_START_US = 1000;
  localparam int T_DELAY_US = 35;
  localparam int T_LONG_MAX_US = 400;
  localparam int T_TX_SHORT_US = 50;
  localparam int T_TX_LONG_US = 100;
  localparam int START_CYC = T_START_US * CLK_MHZ;
  localparam int DELAY_CYC = T_DELAY_US * CLK_MHZ;
  localparam int LONG_MAX_CYC = T_LONG_MAX_US * CLK_MHZ;
  localparam int TX_SHORT_CYC = T_TX_SHORT_US * CLK_MHZ;
  localparam int TX_LONG_CYC = T_TX_LONG_US * CLK_MHZ;
  localparam int I2C_KHZ = 100;
  localparam int I2C_QTR_CYC = (CLK_MHZ * 1000) / (4 * I2C_KHZ);

  // ==========================================================
  // image layout
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [6:0] CHECKSUM_IDX = 7'h0F;
  localparam logic [6:0] LUT_BASE = 7'h10;
  localparam logic [2:0] BLK_LAST_POS = 3'h5;
  localparam logic [3:0] BLK_LAST = 4'hF;
  localparam logic [7:0] BP_END = 8'hFF;
  localparam int IMG_BYTES = 112;
  localparam logic [7:0] IMG_LIMIT = 8'h70;
  localparam logic [2:0] LUT_BREAKPOINT_POS = 3'h0;
  localparam logic [2:0] LUT_GAIN_CHAN_A_POS = 3'h1;
  localparam logic [2:0] LUT_GAIN_CHAN_B_POS = 3'h2;
  localparam logic [2:0] LUT_OFFSET_CHAN_A_POS = 3'h3;
  localparam logic [2:0] LUT_OFFSET_CHAN_B_POS = 3'h4;
  localparam logic [2:0] LUT_OFFSET_CHAN_Z_POS = 3'h5;

  // ==========================================================
  // single-wire frame
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [4:0] RD_BITS = 5'h0B;
  localparam logic [4:0] WR_BITS = 5'h13;

  typedef enum logic [2:0] {
    OP_START = 3'h1,
    OP_STOP = 3'h2,
    OP_XFER = 3'h4
  } ecl_op_t;

endpackage

// ===== verilog/ecl_i2c_engine.sv
// Purpose: i2c bus primitives: start, stop, nine-bit byte transfer
// Assumes: open-drain pins, no clock stretching by the slave
// Notes: one quarter of a bit period per step
`timescale 1ns/1ps
module ecl_i2c_engine #(
  parameter int QTR_CYC = ecl_pkg::I2C_QTR_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire ecl_pkg::ecl_op_t op_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic ack_i,
  input wire logic sda_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic nack_o,
  output logic scl_oe_o,
  output logic sda_oe_o
);

  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_START = 4'h2,
    E_STOP = 4'h4,
    E_XFER = 4'h8
  } ecl_est_t;

  typedef struct packed {
    ecl_est_t st;
    logic [1:0] q;
    logic [15:0] tick;
    logic [3:0] slot;
    logic [8:0] tx;
    logic [8:0] rx;
    logic scl_low;
    logic sda_low;
    logic done;
    logic [2:0] sync;
    logic sda;
  } ecl_eng_t;

  ecl_eng_t r;
  ecl_eng_t n;

  // ==========================================================
  // next state
  always_comb
  begin
    logic step;
    step = (r.tick == 16'(QTR_CYC - 1));
    n = r;
    n.done = 1'b0;
    n.sync = {r.sync[1:0], sda_i};
    if (r.sync[1] == r.sync[2])
      n.sda = r.sync[2];
    if (r.st != E_IDLE)
      n.tick = step ? 16'h0000 : r.tick + 16'h0001;
    if (step)
      n.q = r.q + 2'h1;
    case (r.st)
      E_IDLE:
        if (go_i)
        begin
          n.st = (op_i == ecl_pkg::OP_START) ? E_START :
                 (op_i == ecl_pkg::OP_STOP) ? E_STOP : E_XFER;
          n.q = 2'h0;
          n.tick = 16'h0000;
          n.slot = 4'h0;
          n.tx = rd_i ? {8'hFF, ~ack_i} : {wdata_i, 1'b1};
        end
      E_START:
        if (step)
          case (r.q)
            2'h0: n.sda_low = 1'b0;
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b1;
            default:
            begin
              n.scl_low = 1'b1;
              n.done = 1'b1;
              n.st = E_IDLE;
            end
          endcase
      E_STOP:
        if (step)
          case (r.q)
            2'h0: n.sda_low = 1'b1;
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b0;
            default:
            begin
              n.done = 1'b1;
              n.st = E_IDLE;
            end
          endcase
      E_XFER:
        if (step)
          case (r.q)
            2'h0: n.sda_low = ~r.tx[8];
            2'h1: n.scl_low = 1'b0;
            2'h2: n.rx = {r.rx[7:0], r.sda};
            default:
            begin
              n.scl_low = 1'b1;
              n.tx = {r.tx[7:0], 1'b1};
              n.slot = r.slot + 4'h1;
              if (r.slot == 4'h8)
              begin
                // sda stays put while scl falls; next op sets it a quarter later
                n.done = 1'b1;
                n.st = E_IDLE;
              end
            end
          endcase
      default: n.st = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= E_IDLE;
      r.sync <= 3'h7;
      r.sda <= 1'b1;
    end
    else
      r <= n;
  end

  assign done_o = r.done;
  assign rdata_o = r.rx[8:1];
  assign nack_o = r.rx[0];
  assign scl_oe_o = r.scl_low;
  assign sda_oe_o = r.sda_low;

endmodule

// ===== verilog/ecl_loader_top.sv
// Purpose: startup image loader from i2c eeprom plus single-wire access port
// Assumes: wire and sda pulled high outside; oe high pulls the pin low
// Notes: register bank copies eeprom image locations 0x01 up to the end of the last table block read, at most 0x6F
`timescale 1ns/1ps
module ecl_loader_top #(
  parameter int START_CYC = ecl_pkg::START_CYC,
  parameter int TX_SHORT_CYC = ecl_pkg::TX_SHORT_CYC,
  parameter int TX_LONG_CYC = ecl_pkg::TX_LONG_CYC,
  parameter logic [6:0] EE_DEV_ADDR = ecl_pkg::EE_DEV_ADDR
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wire_i,
  output logic wire_oe_o,
  input wire logic sda_i,
  output logic sda_oe_o,
  output logic scl_oe_o,
  output logic error_out_n_o,
  output logic load_done_o
);

  localparam logic [15:0] START_LIM = 16'(START_CYC);
  localparam logic [15:0] DELAY_LIM = 16'(ecl_pkg::DELAY_CYC);
  localparam logic [15:0] LONG_MAX_LIM = 16'(ecl_pkg::LONG_MAX_CYC);
  localparam logic [15:0] SHORT_LIM = 16'(TX_SHORT_CYC);
  localparam logic [15:0] LONG_LIM = 16'(TX_LONG_CYC);

  typedef enum logic [8:0] {
    I_IDLE = 9'h001,
    I_START = 9'h002,
    I_DEVW = 9'h004,
    I_ADDR = 9'h008,
    I_DATA = 9'h010,
    I_RST = 9'h020,
    I_DEVR = 9'h040,
    I_READ = 9'h080,
    I_STOP = 9'h100
  } ecl_ip_t;

  typedef enum logic [7:0] {
    W_LOAD = 8'h01,
    W_IDLE = 8'h02,
    W_START = 8'h04,
    W_HIGH = 8'h08,
    W_LOW = 8'h10,
    W_TURN = 8'h20,
    W_TXH = 8'h40,
    W_TXL = 8'h80
  } ecl_wp_t;

  typedef struct packed {
    ecl_ip_t ip;
    ecl_wp_t wp;
    logic go;
    ecl_pkg::ecl_op_t op;
    logic [7:0] wdat;
    logic rd;
    logic ack;
    logic pend;
    logic loading;
    logic fail;
    logic ee_wr;
    logic [6:0] ee_addr;
    logic [7:0] ee_data;
    logic [6:0] idx;
    logic [2:0] pos;
    logic [3:0] blk;
    logic end_seen;
    logic [7:0] sum;
    logic [ecl_pkg::IMG_BYTES-1:0][7:0] bank;
    logic [2:0] sync;
    logic w;
    logic [15:0] cnt;
    logic [15:0] hi_len;
    logic [4:0] nbits;
    logic [18:0] sh;
    logic [7:0] tx;
    logic [2:0] tx_bit;
    logic oe;
    logic err_n;
    logic done;
    logic [15:0] ph_len;
  } ecl_state_t;

  ecl_state_t r;
  ecl_state_t n;
  logic eng_done;
  logic [7:0] eng_rdata;
  logic eng_nack;

  ecl_i2c_engine u_eng (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(r.go),
    .op_i(r.op),
    .wdata_i(r.wdat),
    .rd_i(r.rd),
    .ack_i(r.ack),
    .sda_i(sda_i),
    .done_o(eng_done),
    .rdata_o(eng_rdata),
    .nack_o(eng_nack),
    .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic [18:0] nsh;
    logic last;
    logic [7:0] reg_rd;
    ecl_ip_t p_next;
    ecl_pkg::ecl_op_t p_op;
    logic [7:0] p_wdat;
    nsh = {r.sh[17:0], (r.hi_len > r.cnt)};
    last = !r.loading || (r.pos == ecl_pkg::BLK_LAST_POS && r.idx >= ecl_pkg::LUT_BASE
           && (r.end_seen || r.blk == ecl_pkg::BLK_LAST));
    reg_rd = (r.sh[7:0] != 8'h00 && r.sh[7:0] < ecl_pkg::IMG_LIMIT) ? r.bank[r.sh[6:0]] : 8'h00;
    p_op = ecl_pkg::OP_XFER;
    p_wdat = 8'hFF;
    p_next = I_IDLE;
    n = r;
    n.go = 1'b0;
    n.sync = {r.sync[1:0], wire_i};
    if (r.sync[1] == r.sync[2])
      n.w = r.sync[2];

    // ==========================================================
    // eeprom transaction
    case (r.ip)
      I_START:
      begin
        p_op = ecl_pkg::OP_START;
        p_next = I_DEVW;
      end
      I_DEVW:
      begin
        p_wdat = {EE_DEV_ADDR, 1'b0};
        p_next = I_ADDR;
      end
      I_ADDR:
      begin
        p_wdat = {1'b0, r.ee_addr};
        p_next = r.ee_wr ? I_DATA : I_RST;
      end
      I_DATA:
      begin
        p_wdat = r.ee_data;
        p_next = I_STOP;
      end
      I_RST:
      begin
        p_op = ecl_pkg::OP_START;
        p_next = I_DEVR;
      end
      I_DEVR:
      begin
        p_wdat = {EE_DEV_ADDR, 1'b1};
        p_next = I_READ;
      end
      I_READ: p_next = last ? I_STOP : I_READ;
      I_STOP:
      begin
        p_op = ecl_pkg::OP_STOP;
        p_next = I_IDLE;
      end
      default: p_next = I_IDLE;
    endcase
    if (r.ip != I_IDLE && !r.pend)
    begin
      n.go = 1'b1;
      n.pend = 1'b1;
      n.op = p_op;
      n.wdat = p_wdat;
      n.rd = (r.ip == I_READ);
      n.ack = !last;
    end
    else if (r.ip != I_IDLE && eng_done)
    begin
      n.pend = 1'b0;
      n.ip = p_next;
      if (r.op == ecl_pkg::OP_XFER && !r.rd && eng_nack)
      begin
        n.ip = I_STOP;
        n.fail = 1'b1;
      end
      if (r.ip == I_READ && !r.loading)
        n.ee_data = eng_rdata;
      else if (r.ip == I_READ)
      begin
        if (r.idx != 7'h00)
          n.bank[r.idx] = eng_rdata;
        if (r.idx != 7'h00 && r.idx != ecl_pkg::CHECKSUM_IDX)
          n.sum = r.sum + eng_rdata;
        if (r.idx >= ecl_pkg::LUT_BASE)
        begin
          if (r.pos == ecl_pkg::LUT_BREAKPOINT_POS && eng_rdata == ecl_pkg::BP_END
              && r.blk != 4'h0)
            n.end_seen = 1'b1;
          n.pos = (r.pos == ecl_pkg::BLK_LAST_POS) ? 3'h0 : r.pos + 3'h1;
          if (r.pos == ecl_pkg::BLK_LAST_POS)
            n.blk = r.blk + 4'h1;
        end
        n.idx = r.idx + 7'h01;
      end
      if (r.ip == I_STOP && r.loading)
      begin
        n.loading = 1'b0;
        n.wp = W_IDLE;
        n.cnt = 16'h0000;
        if (r.fail || r.sum != r.bank[ecl_pkg::CHECKSUM_IDX])
          n.err_n = 1'b0;
        else
          n.done = 1'b1;
      end
      if (r.ip == I_STOP)
        n.fail = 1'b0;
    end

    // ==========================================================
    // single-wire port
    case (r.wp)
      W_LOAD: n.cnt = 16'h0000;
      W_IDLE:
      begin
        n.cnt = r.w ? 16'h0000 : r.cnt + 16'h0001;
        if (r.cnt >= START_LIM)
          n.wp = W_START;
      end
      W_START:
        if (r.w)
        begin
          n.wp = W_HIGH;
          n.cnt = 16'h0000;
          n.nbits = 5'h00;
        end
      W_HIGH:
      begin
        n.cnt = r.cnt + 16'h0001;
        if (!r.w)
        begin
          n.hi_len = r.cnt;
          n.cnt = 16'h0000;
          n.wp = W_LOW;
        end
        else if (r.cnt >= LONG_MAX_LIM)
        begin
          n.cnt = 16'h0000;
          n.wp = W_IDLE;
        end
      end
      W_LOW:
      begin
        n.cnt = r.cnt + 16'h0001;
        if (r.cnt >= START_LIM)
          n.wp = W_START;
        else if (r.w)
        begin
          n.cnt = 16'h0000;
          n.sh = nsh;
          n.nbits = r.nbits + 5'h01;
          n.wp = W_HIGH;
          if (r.nbits == ecl_pkg::RD_BITS - 5'h01 && nsh[10:8] == ecl_pkg::CMD_READ)
          begin
            n.wp = W_TURN;
            n.oe = 1'b1;
            if (nsh[7] && r.ip == I_IDLE)
            begin
              n.ip = I_START;
              n.ee_wr = 1'b0;
              n.ee_addr = nsh[6:0];
            end
          end
          else if (r.nbits == ecl_pkg::RD_BITS - 5'h01 && nsh[10:8] != ecl_pkg::CMD_WRITE)
            n.wp = W_IDLE;
          else if (r.nbits == ecl_pkg::WR_BITS - 5'h01)
          begin
            n.wp = W_IDLE;
            if (nsh[15] && r.ip == I_IDLE)
            begin
              n.ip = I_START;
              n.ee_wr = 1'b1;
              n.ee_addr = nsh[14:8];
              n.ee_data = nsh[7:0];
            end
            else if (!nsh[15] && nsh[15:8] != 8'h00 && nsh[15:8] < ecl_pkg::IMG_LIMIT)
              n.bank[nsh[14:8]] = nsh[7:0];
          end
        end
      end
      W_TURN:
      begin
        n.cnt = r.cnt + 16'h0001;
        if (r.cnt >= DELAY_LIM - 16'h0001 && r.ip == I_IDLE)
        begin
          n.tx = r.sh[7] ? r.ee_data : reg_rd;
          n.tx_bit = 3'h0;
          n.cnt = 16'h0000;
          n.oe = 1'b0;
          n.wp = W_TXH;
        end
      end
      W_TXH:
      begin
        n.cnt = r.cnt + 16'h0001;
        if (r.cnt == (r.tx[7] ? LONG_LIM : SHORT_LIM) - 16'h0001)
        begin
          n.cnt = 16'h0000;
          n.oe = 1'b1;
          n.wp = W_TXL;
        end
      end
      W_TXL:
      begin
        n.cnt = r.cnt + 16'h0001;
        if (r.cnt == (r.tx[7] ? SHORT_LIM : LONG_LIM) - 16'h0001)
        begin
          n.cnt = 16'h0000;
          n.oe = 1'b0;
          n.tx = {r.tx[6:0], 1'b0};
          n.tx_bit = r.tx_bit + 3'h1;
          n.wp = (r.tx_bit == 3'h7) ? W_IDLE : W_TXH;
        end
      end
      default: n.wp = W_IDLE;
    endcase
    n.ph_len = (n.wp != r.wp) ? 16'h0000 : r.ph_len + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.ip <= I_START;
      r.wp <= W_LOAD;
      r.op <= ecl_pkg::OP_START;
      r.loading <= 1'b1;
      r.err_n <= 1'b1;
      r.sync <= 3'h7;
      r.w <= 1'b1;
    end
    else
      r <= n;
  end

  assign wire_oe_o = r.oe;
  assign error_out_n_o = r.err_n;
  assign load_done_o = r.done;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_LOAD_BEFORE_WIRE:
    assert property (r.loading |-> !wire_oe_o && !load_done_o)
      else $error("wire driven or run before load end");
  AST_RUN_ON_MATCH:
    assert property ($rose(load_done_o) |-> $past(r.sum) == $past(r.bank[15]) && error_out_n_o)
      else $error("run entered without checksum match");
  AST_ERR_ON_MISMATCH:
    assert property ($fell(error_out_n_o) |->
      $past(r.fail) || $past(r.sum) != $past(r.bank[15]))
      else $error("error pin low without mismatch");
  AST_SUM_SKIPS_STORED:
    assert property ((r.ip == I_READ && eng_done && r.loading && r.idx == 7'h0F)
      |=> $stable(r.sum))
      else $error("stored checksum entered the sum");
  AST_CFG_COPY:
    assert property ((r.ip == I_READ && eng_done && r.loading && r.idx != 7'h00)
      |=> r.bank[$past(r.idx)] == $past(eng_rdata))
      else $error("image byte not copied to bank");
  AST_STOP_AFTER_END:
    assert property (r.loading && r.ip == I_READ |-> !(r.end_seen && r.pos == 3'h0))
      else $error("reading beyond final table block");
  AST_BLOCK_POS:
    assert property (r.loading && r.idx >= 7'h10 && r.idx < 7'h70
      |-> (int'(r.idx) - 16) % 6 == int'(r.pos))
      else $error("table field position out of step");
  AST_TURN_DELAY:
    assert property ((r.wp == W_TURN && n.wp == W_TXH) |->
      r.ph_len >= DELAY_LIM - 16'h0001 && wire_oe_o)
      else $error("turnaround shorter than minimum");
  AST_TX_HIGH_LEN:
    assert property ((r.wp == W_TXH && n.wp == W_TXL) |->
      r.ph_len == (r.tx[7] ? LONG_LIM : SHORT_LIM) - 16'h0001 && !wire_oe_o)
      else $error("transmit high phase length wrong");
  AST_TX_UNITS:
    assert property (r.wp == W_TXL |-> r.ph_len < LONG_LIM && wire_oe_o)
      else $error("transmit low phase too long");

  COV_LOAD_OK: cover property ($rose(load_done_o));
  COV_LOAD_BAD: cover property ($fell(error_out_n_o));
  COV_WIRE_READ: cover property (r.wp == W_TXL && n.wp == W_IDLE);
  COV_EE_WRITE: cover property (r.ip == I_DATA && eng_done);

endmodule

// ===== verif/ecl_ee_model.sv
// Purpose: behavioural i2c eeprom holding the startup image
// Assumes: open-drain bus with pull-ups, no clock stretching
// Notes: sda_pull_o high pulls sda low; mem is loaded by the bench
`timescale 1ns/1ps
module ecl_ee_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_pull_o
);
  // ==========================================================
  // storage and framing; st: 0 dev, 1 word addr, 2 write, 3 read, 4 idle, 5 read armed
  logic [7:0] mem [0:127];
  logic [7:0] sh;
  logic [6:0] ptr;
  int bits;
  int st;

  initial
  begin
    sda_pull_o = 1'b0;
    bits = 0;
    st = 4;
    ptr = 7'h00;
  end

  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin
      bits = 0;
      st = 0;
    end

  always @(posedge sda_i)
    if (scl_i === 1'b1)
      st = 4;

  always @(posedge scl_i)
  begin
    sh = {sh[6:0], sda_i};
    bits = bits + 1;
  end

  // ==========================================================
  // ack and data driven while scl is low
  always @(negedge scl_i)
  begin
    sda_pull_o = 1'b0;
    if (bits == 8 && st < 3)
    begin
      sda_pull_o = (st != 0) || (sh[7:1] == DEV_ADDR);
      if (st == 0)
        st = (sh[7:1] != DEV_ADDR) ? 4 : (sh[0] ? 5 : 1);
      else if (st == 1)
      begin
        ptr = sh[6:0];
        st = 2;
      end
      else
      begin
        mem[ptr] = sh;
        ptr = ptr + 7'h01;
      end
    end
    else if (bits == 9)
    begin
      bits = 0;
      if (st == 3)
        st = sh[0] ? 4 : 3;
      if (st == 3 && sh[0] == 1'b0)
        ptr = ptr + 7'h01;
      if (st == 5)
        st = 3;
    end
    if (st == 3 && bits < 8)
      sda_pull_o = ~mem[ptr][7 - bits];
  end
endmodule

// ===== verif/testbench.sv
// Purpose: self-checking bench for the loader and its single-wire port
// Assumes: unit, start and idle lengths scaled down together for run time
// Notes: the bench plays the single-wire master; an eeprom model sits on i2c
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // scaled master timing
  localparam int START_LEN = 220;
  localparam int IDLE = 600;
  localparam int IDLE_EE = 5000;
  logic clk_i;
  logic rst_i;
  logic m_pull;
  logic ee_pull;
  logic wire_oe_o;
  logic sda_oe_o;
  logic scl_oe_o;
  logic error_out_n_o;
  logic load_done_o;
  logic wire_lvl;
  logic sda_lvl;
  logic scl_lvl;
  logic st_seen;
  logic [1:0] exp_stat[$];
  logic [7:0] exp_byte[$];
  int seed;
  int failures;
  int total_checks;

  assign wire_lvl = ~(wire_oe_o | m_pull);
  assign sda_lvl = ~(sda_oe_o | ee_pull);
  assign scl_lvl = ~scl_oe_o;

  ecl_loader_top #(
    .START_CYC(200),
    .TX_SHORT_CYC(40),
    .TX_LONG_CYC(80)
  ) dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wire_i(wire_lvl),
    .wire_oe_o(wire_oe_o),
    .sda_i(sda_lvl),
    .sda_oe_o(sda_oe_o),
    .scl_oe_o(scl_oe_o),
    .error_out_n_o(error_out_n_o),
    .load_done_o(load_done_o)
  );

  ecl_ee_model ee (
    .scl_i(scl_lvl),
    .sda_i(sda_lvl),
    .sda_pull_o(ee_pull)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================
  // compare and report
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected=%h seen=%h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected=%b seen=%b", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // single-wire master
  task automatic hold(input logic v, input int n);
    m_pull <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wire_frame(input logic [2:0] cmd, input logic [7:0] adr, input logic [7:0] dat);
    logic [18:0] f;
    int n;
    int s;
    f = {cmd, adr, dat};
    n = (cmd == ecl_pkg::CMD_WRITE) ? 19 : 11;
    hold(1'b1, START_LEN);
    for (int i = 18; i > 18 - n; i--)
    begin
      s = 30 + ($random(seed) & 15);
      hold(1'b0, f[i] ? 2 * s + 10 : s);
      hold(1'b1, f[i] ? s : 2 * s + 10);
    end
    m_pull <= 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_byte.size() + exp_stat.size() != 0 && n < 60000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 60000)
    begin
      failures++;
      $display("[ERR] result wait expected=result seen=none");
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat, input int idle);
    wire_frame(ecl_pkg::CMD_WRITE, adr, dat);
    repeat (idle) @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    exp_byte.push_back(exp);
    wire_frame(ecl_pkg::CMD_READ, adr, 8'h00);
    drain();
    hold(1'b0, IDLE);
  endtask

  // ==========================================================
  // result watchers
  initial
  begin : watch_status
    logic [1:0] e;
    st_seen = 1'b0;
    forever
    begin
      @(negedge clk_i);
      if (rst_i === 1'b1)
        st_seen = 1'b0;
      else if (!st_seen && (load_done_o === 1'b1 || error_out_n_o === 1'b0))
      begin
        st_seen = 1'b1;
        e = (exp_stat.size() != 0) ? exp_stat.pop_front() : 2'bxx;
        chk_bit("load done", e[1], load_done_o);
        chk_bit("error out n", e[0], error_out_n_o);
      end
    end
  end

  initial
  begin : watch_reply
    int n;
    int h;
    int l;
    logic [7:0] b;
    forever
    begin
      @(negedge clk_i);
      if (rst_i === 1'b0 && wire_oe_o === 1'b1)
      begin
        n = 1;
        while (wire_oe_o === 1'b1 && n < 20000)
        begin
          @(negedge clk_i);
          n++;
        end
        chk_bit("turnaround", 1'b1, n >= ecl_pkg::DELAY_CYC && n < 20000);
        for (int i = 0; i < 8; i++)
        begin
          h = 0;
          while (wire_oe_o === 1'b0 && h < 4000)
          begin
            @(negedge clk_i);
            h++;
          end
          l = 0;
          while (wire_oe_o === 1'b1 && l < 4000)
          begin
            @(negedge clk_i);
            l++;
          end
          chk_bit("reply phase", 1'b1, h < 4000 && l < 4000);
          b = {b[6:0], h > l};
        end
        chk_byte("read data", (exp_byte.size() != 0) ? exp_byte.pop_front() : 8'hXX, b);
      end
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin : main_seq
    logic [7:0] sum;
    logic [7:0] d;
    seed = 32'h8fb2a5cf;
    failures = 0;
    total_checks = 0;
    rst_i = 1'b1;
    m_pull = 1'b0;
    for (int a = 0; a < 128; a++)
      ee.mem[a] = $random(seed);
    // end marker in block 0 must not end the table
    ee.mem[16] = 8'hFF;
    ee.mem[22] = 8'hFF;
    sum = 8'h00;
    for (int a = 1; a < 28; a++)
      if (a != 15)
        sum = sum + ee.mem[a];
    ee.mem[15] = sum;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    exp_stat.push_back(2'b11);
    drain();
    hold(1'b0, 20);
    d = $random(seed);
    wr(8'h05, d, IDLE);
    rd(8'h05, d);
    rd(8'h00, 8'h00);
    rd(8'h0E, ee.mem[14]);
    rd(8'h0F, sum);
    rd(8'h16, 8'hFF);
    d = $random(seed);
    wr(8'hA0, d, IDLE_EE);
    chk_byte("eeprom cell", d, ee.mem[32]);
    rd(8'hA0, d);
    ee.mem[15] = ~sum;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    exp_stat.push_back(2'b00);
    drain();
    print_verdict();
  end
endmodule
